// *** src/sacag_top.sv ***
// Effective-address generator: software stack, addressing modes and circular correction.
// Assumes an execution unit issuing one request per cycle and an APB master for the registers.
// Operation
// - Stack pointer holds next free word; stack grows upward.
// - Pop decrements before reading; push writes then increments.
// - Call push clears the top bit of the pushed program counter.
// - Exception push places status low byte above the program counter.
// - Limit bit zero is forced to zero; limit has no reset value.
// - Every address formed through the stack pointer, except a pop's, is checked against the limit.
// - Push at pointer equal to limit is fine; the following push traps.
// - Stack address below 0x0800 raises the stack error.
// - File mode uses a 13-bit field; register zero is the accumulator.
// - Three-operand: first operand register direct; second register, memory or 5-bit literal.
// - Indexed adds base register, literal offset adds literal; pointer unchanged.
// - Pre-modify adjusts then uses; post-modify uses then adjusts.
// - Moves share one 4-bit offset register field for source and destination.
// - Dual-operand pointers are registers 8 to 11; 8,9 to X, 10,11 to Y.
// - Dual-operand indexing only on 9 and 11; post-steps only 2, 4, 6, up or down.
// - One circular buffer per space, length from start and end, up to 32K words.
// - Y-space circular addresses are word aligned.
// - X correction needs X select not 15 and X enable set.
// - Y correction needs Y select not 15 and Y enable set.
// - Wrap when passing the upper bound upward or lower bound downward.
// - Corrected address written back only in pre- or post-modify modes.
`timescale 1ns/1ps
`include "sacag_cfg.svh"

module sacag_top (
    // Clock, reset, enable
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 ce,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Execution unit request
    input  wire sacag_pkg::sacag_req_s req,
    output logic                      req_ready,
    // Memory access, register write-back, operand routing
    output sacag_pkg::sacag_mem_s     mem,
    output sacag_pkg::sacag_wb_s      wb,
    output sacag_pkg::sacag_opnd_s    opnd,
    // Events
    output logic                      stack_err,
    output logic                      illegal
);
    typedef enum logic {ST_IDLE, ST_HI} sacag_state_e;

    function automatic logic [3:0] reg_sel(input logic [11:0] a);
        case (a)
            `SACAG_OFS_CTRL:  reg_sel = 4'h1;
            `SACAG_OFS_STACK_LIMIT_REGISTER: reg_sel = 4'h2;
            `SACAG_OFS_XSRT:  reg_sel = 4'h3;
            `SACAG_OFS_XEND:  reg_sel = 4'h4;
            `SACAG_OFS_YSRT:  reg_sel = 4'h5;
            `SACAG_OFS_YEND:  reg_sel = 4'h6;
            `SACAG_OFS_SP:    reg_sel = 4'h7;
            `SACAG_OFS_STAT:  reg_sel = 4'h8;
            default:          reg_sel = 4'h0;
        endcase
    endfunction

    sacag_state_e          state_q;
    logic                  exc_q;
    logic [15:0]           hi_pc_q;
    logic [7:0]            srl_q;
    logic [15:0]           ctrl_q, stack_limit_register_q, xsrt_q, xend_q, ysrt_q, yend_q, sp_q;
    logic [2:0]            stat_q;
    logic [31:0]           prdata_q;
    logic                  pready_q, pslverr_q, ready_q;
    sacag_pkg::sacag_mem_s  mem_q, mem_d;
    sacag_pkg::sacag_wb_s   wb_q, wb_d;
    sacag_pkg::sacag_opnd_s opnd_q, opnd_d;
    logic                  err_q, err_d, ill_q, ill_d, ovf_d, unf_d;
    logic [15:0]           sp_d, ptr, ea_pre, new_ptr, mod_in, mod_out, m_start, m_stop, chk;
    logic                  go, apb_wr, mod_en, wrapped, down;
    sacag_pkg::sacag_space_e space;
    logic [3:0]            wsel;

    assign go     = ce && req.valid && ready_q && state_q == ST_IDLE;
    assign apb_wr = ce && psel && penable && pready_q && pwrite;
    assign wsel   = reg_sel(paddr);

    // ****************************************
    // APB slave: one wait-free access phase, read data captured in setup
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else if (ce) begin
            pready_q  <= psel && !penable;
            pslverr_q <= psel && !penable && wsel == 4'h0;
            if (psel && !penable) begin
                case (wsel)
                    4'h1:    prdata_q <= {16'h0000, ctrl_q};
                    4'h2:    prdata_q <= {16'h0000, stack_limit_register_q};
                    4'h3:    prdata_q <= {16'h0000, xsrt_q};
                    4'h4:    prdata_q <= {16'h0000, xend_q};
                    4'h5:    prdata_q <= {16'h0000, ysrt_q};
                    4'h6:    prdata_q <= {16'h0000, yend_q};
                    4'h7:    prdata_q <= {16'h0000, sp_q};
                    4'h8:    prdata_q <= {29'h0000_0000, stat_q};
                    default: prdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `SACAG_CTRL_RST;
            xsrt_q <= `SACAG_BUF_RST;
            xend_q <= `SACAG_BUF_RST;
            ysrt_q <= `SACAG_BUF_RST;
            yend_q <= `SACAG_BUF_RST;
        end else if (apb_wr) begin
            case (wsel)
                4'h1:    ctrl_q <= pwdata[15:0];
                4'h3:    xsrt_q <= pwdata[15:0];
                4'h4:    xend_q <= pwdata[15:0];
                4'h5:    ysrt_q <= pwdata[15:0];
                4'h6:    yend_q <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // The limit is deliberately left without reset; software must load it before use.
    always_ff @(posedge pclk) begin
        if (apb_wr && wsel == 4'h2) begin
            stack_limit_register_q <= {pwdata[15:1], 1'b0};
        end
    end

    // Sticky error flags, write one to clear; a new event wins over the clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= 3'b000;
        end else if (ce) begin
            stat_q <= (stat_q & ~((apb_wr && wsel == 4'h8) ? pwdata[2:0] : 3'b000)) | {ill_d, unf_d, ovf_d};
        end
    end

    // ****************************************
    // Address formation
    // ****************************************
    assign ptr     = (req.ptr_idx == `SACAG_SP_IDX) ? sp_q : req.ptr_val;
    assign new_ptr = ptr + req.step;
    assign space   = !req.mac ? req.space : (req.ptr_idx[1] ? sacag_pkg::SPACE_Y : sacag_pkg::SPACE_XR);
    assign down    = (req.mode == sacag_pkg::MODE_IDX) ? req.ofs_val[15] : req.step[15];

    always_comb begin
        case (req.mode)
            sacag_pkg::MODE_PRE:    ea_pre = new_ptr;
            sacag_pkg::MODE_IDX:    ea_pre = ptr + req.ofs_val;
            sacag_pkg::MODE_LITOFS: ea_pre = ptr + req.step;
            default:                ea_pre = ptr;
        endcase
    end

    always_comb begin
        if (space == sacag_pkg::SPACE_Y) begin
            mod_en  = ctrl_q[`SACAG_YEN_BIT] && ctrl_q[`SACAG_YSEL_LSB +: 4] != `SACAG_SEL_OFF
                      && req.ptr_idx == ctrl_q[`SACAG_YSEL_LSB +: 4];
            m_start = ysrt_q;
            m_stop  = yend_q;
        end else begin
            mod_en  = ctrl_q[`SACAG_XEN_BIT] && ctrl_q[`SACAG_XSEL_LSB +: 4] != `SACAG_SEL_OFF
                      && req.ptr_idx == ctrl_q[`SACAG_XSEL_LSB +: 4];
            m_start = xsrt_q;
            m_stop  = xend_q;
        end
    end

    assign mod_in = (req.mode == sacag_pkg::MODE_POST) ? new_ptr : ea_pre;

    sacag_modulo u_modulo (
        .en       (mod_en),
        .word     (space == sacag_pkg::SPACE_Y),
        .down     (down),
        .start    (m_start),
        .stop     (m_stop),
        .addr     (mod_in),
        .addr_out (mod_out),
        .wrapped  (wrapped)
    );

    // ****************************************
    // Request decode
    // ****************************************
    always_comb begin
        mem_d  = '0;
        wb_d   = '0;
        opnd_d = '0;
        sp_d   = sp_q;
        ill_d  = 1'b0;
        chk    = ptr;
        if (state_q == ST_HI) begin
            // Second word of a program-counter push; the top bit stays clear for calls.
            mem_d = '{1'b1, 1'b1, sp_q, exc_q ? {srl_q, hi_pc_q[7:0]} : hi_pc_q};
            sp_d  = sp_q + `SACAG_WORD_STEP;
            chk   = sp_q;
        end else if (go) begin
            case (req.kind)
                sacag_pkg::KIND_PUSH, sacag_pkg::KIND_CALL, sacag_pkg::KIND_EXC: begin
                    mem_d = '{1'b1, 1'b1, sp_q,
                              req.kind == sacag_pkg::KIND_PUSH ? req.wdata : req.pc[15:0]};
                    sp_d  = sp_q + `SACAG_WORD_STEP;
                    chk   = sp_q;
                end
                sacag_pkg::KIND_POP: begin
                    sp_d  = sp_q - `SACAG_WORD_STEP;
                    mem_d = '{1'b1, 1'b0, sp_d, 16'h0000};
                    chk   = sp_d;
                end
                default: begin
                    if (req.mac) begin
                        ill_d = req.ptr_idx[3:2] != 2'b10
                                || (req.mode == sacag_pkg::MODE_IDX && !req.ptr_idx[0])
                                || (req.mode == sacag_pkg::MODE_POST && !(req.step == 16'h0002
                                    || req.step == 16'h0004 || req.step == 16'h0006 || req.step == 16'hFFFE
                                    || req.step == 16'hFFFC || req.step == 16'hFFFA))
                                || !(req.mode == sacag_pkg::MODE_IND || req.mode == sacag_pkg::MODE_POST
                                     || req.mode == sacag_pkg::MODE_IDX);
                    end
                    case (req.mode)
                        sacag_pkg::MODE_FILE: begin
                            mem_d  = '{1'b1, space == sacag_pkg::SPACE_XW, {3'b000, req.lit}, req.wdata};
                            opnd_d = '{req.to_implied_accumulator_register, 1'b0, `SACAG_IMPLIED_ACCUMULATOR_REGISTER_IDX, 16'h0000};
                        end
                        sacag_pkg::MODE_REG: opnd_d = '{1'b1, 1'b0, req.ptr_idx, 16'h0000};
                        sacag_pkg::MODE_LIT5: opnd_d = '{1'b1, 1'b1, 4'h0, {11'h000, req.lit[4:0]}};
                        sacag_pkg::MODE_POST, sacag_pkg::MODE_PRE: begin
                            mem_d = '{!ill_d, space == sacag_pkg::SPACE_XW,
                                      req.mode == sacag_pkg::MODE_POST ? ptr : mod_out, req.wdata};
                            wb_d  = '{!ill_d, req.ptr_idx, mod_out};
                            if (!ill_d && req.ptr_idx == `SACAG_SP_IDX) begin
                                sp_d = mod_out;
                            end
                        end
                        default: begin
                            // Indirect, indexed and literal offset: corrected address, pointer kept.
                            mem_d  = '{!ill_d, space == sacag_pkg::SPACE_XW, mod_out, req.wdata};
                            opnd_d = '{req.mode == sacag_pkg::MODE_IDX, 1'b0, req.ofs_idx, 16'h0000};
                        end
                    endcase
                    chk = mem_d.addr;
                end
            endcase
        end
    end

    // Every address formed through the stack pointer is checked against the floor, and all but pop addresses against the limit.
    assign ovf_d = (state_q == ST_HI || (go && req.kind != sacag_pkg::KIND_POP && (req.kind != sacag_pkg::KIND_EA
                    || (req.ptr_idx == `SACAG_SP_IDX && mem_d.valid)))) && chk > stack_limit_register_q;
    assign unf_d = (state_q == ST_HI || (go && (req.kind != sacag_pkg::KIND_EA
                    || (req.ptr_idx == `SACAG_SP_IDX && mem_d.valid)))) && chk < `SACAG_STACK_FLOOR;
    assign err_d = ovf_d || unf_d;

    // ****************************************
    // Stack pointer and program-counter push sequencing
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_q <= `SACAG_SP_RST;
        end else if (ce) begin
            if (sp_d != sp_q) begin
                sp_q <= {sp_d[15:1], 1'b0};
            end else if (apb_wr && wsel == 4'h7) begin
                sp_q <= {pwdata[15:1], 1'b0};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            ready_q <= 1'b0;
            exc_q   <= 1'b0;
            hi_pc_q <= 16'h0000;
            srl_q   <= 8'h00;
        end else if (ce) begin
            case (state_q)
                ST_IDLE: begin
                    ready_q <= 1'b1;
                    if (go && (req.kind == sacag_pkg::KIND_CALL || req.kind == sacag_pkg::KIND_EXC)) begin
                        state_q <= ST_HI;
                        ready_q <= 1'b0;
                        exc_q   <= req.kind == sacag_pkg::KIND_EXC;
                        hi_pc_q <= {9'h000, req.pc[22:16]};
                        srl_q   <= req.status_low_byte;
                    end
                end
                ST_HI: begin
                    state_q <= ST_IDLE;
                    ready_q <= 1'b1;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_q  <= '0;
            wb_q   <= '0;
            opnd_q <= '0;
            err_q  <= 1'b0;
            ill_q  <= 1'b0;
        end else if (ce) begin
            mem_q  <= mem_d;
            wb_q   <= wb_d;
            opnd_q <= opnd_d;
            err_q  <= err_d;
            ill_q  <= ill_d;
        end
    end

    assign prdata    = prdata_q;
    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign req_ready = ready_q;
    assign mem       = mem_q;
    assign wb        = wb_q;
    assign opnd      = opnd_q;
    assign stack_err = err_q;
    assign illegal   = ill_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    push_order_a: assert property ((go && req.kind == sacag_pkg::KIND_PUSH) |=>
        (mem_q.write && mem_q.addr == $past(sp_q) && sp_q == $past(sp_q) + 16'h0002))
        else $error("push did not write at old pointer then increment");
    pop_order_a: assert property ((go && req.kind == sacag_pkg::KIND_POP) |=>
        (!mem_q.write && mem_q.addr == sp_q && sp_q == $past(sp_q) - 16'h0002))
        else $error("pop did not decrement before read");
    call_msb_a: assert property ((ce && state_q == ST_HI && !exc_q) |=> mem_q.wdata[15:7] == 9'h000)
        else $error("call push high word top bits not clear");
    exc_srl_a: assert property ((ce && state_q == ST_HI && exc_q) |=> mem_q.wdata[15:8] == $past(srl_q))
        else $error("exception push lacks status byte");
    limit_lsb_a: assert property ((apb_wr && wsel == 4'h2) |=> {16'h0000, stack_limit_register_q} == ($past(pwdata) & 32'h0000_FFFE))
        else $error("limit write not word aligned");
    push_limit_a: assert property ((go && req.kind == sacag_pkg::KIND_PUSH && sp_q == stack_limit_register_q
        && sp_q >= 16'h0800) |=> !stack_err) else $error("push at limit trapped");
    over_limit_a: assert property ((go && req.kind == sacag_pkg::KIND_PUSH && sp_q > stack_limit_register_q) |=> stack_err)
        else $error("push above limit did not trap");
    floor_a: assert property ((go && req.kind == sacag_pkg::KIND_POP && sp_q - 16'h0002 < 16'h0800) |=> stack_err)
        else $error("underflow below floor not trapped");
    idx_keep_a: assert property ((go && req.kind == sacag_pkg::KIND_EA && req.mode == sacag_pkg::MODE_IDX)
        |=> !wb_q.valid) else $error("indexed mode changed pointer");
    mac_range_a: assert property ((go && req.kind == sacag_pkg::KIND_EA && req.mac && req.ptr_idx < 4'h8)
        |=> illegal && !mem_q.valid) else $error("dual operand outside 8..11 accepted");
    file_addr_a: assert property ((go && req.kind == sacag_pkg::KIND_EA && req.mode == sacag_pkg::MODE_FILE)
        |=> mem_q.addr[15:13] == 3'b000) else $error("file address exceeds 13 bits");

    limit_push_c: cover property (go && req.kind == sacag_pkg::KIND_PUSH && sp_q == stack_limit_register_q);
    wrap_c: cover property (go && req.kind == sacag_pkg::KIND_EA && wrapped);
    exc_push_c: cover property (ce && state_q == ST_HI && exc_q);
endmodule // sacag_top

// *** shared/sacag_cfg.svh ***
// Constants of the stack and circular address generator: offsets, field positions, reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SACAG_CFG_SVH
`define SACAG_CFG_SVH

// ****************************************
// Register byte offsets on the APB side
// ****************************************
`define SACAG_OFS_CTRL      12'h000
`define SACAG_OFS_STACK_LIMIT_REGISTER     12'h004
`define SACAG_OFS_XSRT      12'h008
`define SACAG_OFS_XEND      12'h00C
`define SACAG_OFS_YSRT      12'h010
`define SACAG_OFS_YEND      12'h014
`define SACAG_OFS_SP        12'h018
`define SACAG_OFS_STAT      12'h01C

// ****************************************
// Field positions
// ****************************************
`define SACAG_XEN_BIT       15
`define SACAG_YEN_BIT       14
`define SACAG_XSEL_LSB      0
`define SACAG_YSEL_LSB      4
`define SACAG_SEL_OFF       4'hF
`define SACAG_STAT_OVF      0
`define SACAG_STAT_UNF      1
`define SACAG_STAT_ILL      2

// ****************************************
// Reset values and fixed addresses
// ****************************************
`define SACAG_CTRL_RST      16'h00FF
`define SACAG_BUF_RST       16'h0000
`define SACAG_SP_RST        16'h0800
`define SACAG_STACK_FLOOR   16'h0800
`define SACAG_SP_IDX        4'hF
`define SACAG_IMPLIED_ACCUMULATOR_REGISTER_IDX      4'h0
`define SACAG_WORD_STEP     16'h0002

`endif

// *** shared/sacag_pkg.sv ***
// Types shared by the address generator, its memory model and the bench.
// Assumes the constants header is on the include path.
`include "sacag_cfg.svh"

package sacag_pkg;

    typedef enum logic [2:0] {KIND_EA, KIND_PUSH, KIND_POP, KIND_CALL, KIND_EXC} sacag_kind_e;
    typedef enum logic [2:0] {MODE_FILE, MODE_REG, MODE_IND, MODE_POST, MODE_PRE, MODE_IDX, MODE_LITOFS,
                              MODE_LIT5} sacag_mode_e;
    typedef enum logic [1:0] {SPACE_XR, SPACE_XW, SPACE_Y} sacag_space_e;

    typedef struct packed {
        logic         valid;
        sacag_kind_e  kind;
        sacag_mode_e  mode;
        sacag_space_e space;
        logic         mac;
        logic         to_implied_accumulator_register;
        logic [3:0]   ptr_idx;
        logic [3:0]   ofs_idx;
        logic [15:0]  ptr_val;
        logic [15:0]  ofs_val;
        logic [12:0]  lit;
        logic [15:0]  step;
        logic [15:0]  wdata;
        logic [22:0]  pc;
        logic [7:0]   status_low_byte;
    } sacag_req_s;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } sacag_mem_s;

    typedef struct packed {
        logic        valid;
        logic [3:0]  idx;
        logic [15:0] val;
    } sacag_wb_s;

    typedef struct packed {
        logic        valid;
        logic        is_lit;
        logic [3:0]  idx;
        logic [15:0] lit;
    } sacag_opnd_s;

endpackage

// *** src/sacag_modulo.sv ***
// Circular-buffer correction of one address against one start/end pair.
// Assumes word data when word is high; purely combinational.
`timescale 1ns/1ps

module sacag_modulo (
    // Control
    input  wire logic        en,
    input  wire logic        word,
    input  wire logic        down,
    // Buffer bounds and address
    input  wire logic [15:0] start,
    input  wire logic [15:0] stop,
    input  wire logic [15:0] addr,
    // Result
    output logic      [15:0] addr_out,
    output logic             wrapped
);
    logic [15:0] len;
    logic [15:0] fixed;

    // The length is implied by the bounds; up to 32K words fit in 16 bits.
    assign len = stop - start + 16'h0001;

    always_comb begin
        fixed   = addr;
        wrapped = 1'b0;
        // Compare beyond, not only equal, so steps larger than one word still wrap.
        if (en && !down && addr > stop) begin
            fixed   = addr - len;
            wrapped = 1'b1;
        end else if (en && down && addr < start) begin
            fixed   = addr + len;
            wrapped = 1'b1;
        end
        addr_out = (en && word) ? {fixed[15:1], 1'b0} : fixed;
    end
endmodule // sacag_modulo

// *** verif/sacag_mem_model.sv ***
// Data memory behind the generator: keeps every word written.
// Assumes one access per mem pulse.
`timescale 1ns/1ps
module sacag_mem_model (
    // Clock and access
    input wire logic                  pclk,
    input wire sacag_pkg::sacag_mem_s mem
);
    logic [15:0] word_q [logic [15:0]];
    always @(posedge pclk)
        if (mem.valid && mem.write) word_q[mem.addr] = mem.wdata;
endmodule // sacag_mem_model

// *** verif/sacag_test.sv ***
// Bench: APB register access and execution-unit requests.
// Assumes zero-wait APB and one-cycle answers.
`timescale 1ns/1ps
module stack_and_circular_address_gen_test;
    logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, sl, e, il;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, req_ready, stack_err, illegal;
    sacag_pkg::sacag_req_s req = '0, r;
    sacag_pkg::sacag_mem_s mem, m;
    sacag_pkg::sacag_wb_s wb, w;
    sacag_pkg::sacag_opnd_s opnd, q;
    int failures = 0, comparisons = 0, cyc = 0;
    sacag_top sacag_top_inst (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .req, .req_ready, .mem, .wb, .opnd, .stack_err, .illegal);
    sacag_mem_model sacag_mem_model_inst (.pclk, .mem);
    initial forever #12.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin failures++; summarize(); end
    end
    task summarize;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [15:0] got, exp);
        comparisons++;
        if (got !== exp) begin failures++; $display("mismatch at %0t: %h not %h", $time, got, exp); end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1);
        rd = prdata; sl = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // Kind, mode and {mac, space} are passed as their enum codes.
    task run(input logic [2:0] k, md, sm, input logic [3:0] i, input logic [15:0] p, o, s);
        r = '0; r.valid = 1; r.kind = sacag_pkg::sacag_kind_e'(k); r.mode = sacag_pkg::sacag_mode_e'(md);
        r.space = sacag_pkg::sacag_space_e'(sm[1:0]); r.mac = sm[2]; r.ptr_idx = i; r.ptr_val = p;
        r.ofs_val = o; r.step = s; r.lit = p[12:0]; r.pc = 23'h7F_1234; r.status_low_byte = 8'hA5; r.wdata = 16'h5A5A;
        @(posedge pclk) req <= r;
        do @(posedge pclk); while (req_ready !== 1);
        req <= '0;
        #1 {m, w, e, il, q} = {mem, wb, stack_err, illegal, opnd};
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        apb(0,12'h000,0); chk(rd[15:0],16'h00FF);
        apb(0,12'h020,0); chk(sl,1);
        apb(1,12'h004,32'h0803); apb(0,12'h004,0); chk(rd[15:0],16'h0802);
        $display("test registers done");
        run(1,2,0,15,0,0,2); chk(m.addr,16'h0800); chk(m.wdata,16'h5A5A);
        run(1,2,0,15,0,0,2); chk(e,0);
        run(1,2,0,15,0,0,2); chk(e,1);
        apb(0,12'h01C,0); chk(rd[15:0],16'h0001);
        apb(1,12'h01C,32'h1); apb(0,12'h01C,0); chk(rd[15:0],16'h0000);
        apb(1,12'h004,32'h0FFE); apb(0,12'h018,0); chk(rd[15:0],16'h0806);
        run(2,2,0,15,0,0,2); chk(m.addr,16'h0804); chk(m.write,0); chk(e,0);
        run(3,2,0,15,0,0,2); repeat (3) @(posedge pclk);
        chk(sacag_mem_model_inst.word_q[16'h0806],16'h007F);
        run(4,2,0,15,0,0,2); repeat (3) @(posedge pclk);
        chk(sacag_mem_model_inst.word_q[16'h080A],16'hA57F);
        apb(1,12'h018,32'h0800); run(2,2,0,15,0,0,2); chk(m.addr,16'h07FE); chk(e,1);
        $display("test stack done");
        run(0,5,0,2,16'h1000,16'h10,4); chk(m.addr,16'h1010); chk(w.valid,0);
        run(0,6,0,2,16'h1000,16'h10,4); chk(m.addr,16'h1004); chk(w.valid,0);
        run(0,3,0,2,16'h1000,16'h10,4); chk(m.addr,16'h1000); chk(w.val,16'h1004);
        run(0,4,0,2,16'h1000,16'h10,4); chk(m.addr,16'h1004); chk(w.val,16'h1004);
        run(0,0,0,0,16'hFFFE,0,0); chk(m.addr,16'h1FFE);
        run(0,1,0,3,0,0,0); chk(q.valid,1); chk(q.idx,4'h3); chk(q.is_lit,0);
        run(0,7,0,0,16'h0015,0,0); chk(q.is_lit,1); chk(q.lit,16'h0015); chk(m.valid,0);
        apb(1,12'h008,32'h1000); apb(1,12'h00C,32'h100F); apb(1,12'h000,32'h80F2);
        run(0,3,0,2,16'h100E,0,2); chk(w.val,16'h1000);
        run(0,5,0,2,16'h100E,4,0); chk(m.addr,16'h1002); chk(w.valid,0);
        apb(1,12'h000,32'h00F2); run(0,3,0,2,16'h100E,0,2); chk(w.val,16'h1010);
        apb(1,12'h010,32'h2000); apb(1,12'h014,32'h200F); apb(1,12'h000,32'h402F);
        run(0,3,2,2,16'h200E,0,2); chk(w.val,16'h2000);
        run(0,5,4,8,16'h1000,2,0); chk(il,1); chk(m.valid,0);
        run(0,3,4,10,16'h3000,0,6); chk(il,0); chk(m.addr,16'h3000);
        $display("test modes done");
        summarize();
    end
endmodule // stack_and_circular_address_gen_test
